/* File: rtl/fifo_ctrl.sv */
// Purpose: fifo control unit around variable-aspect on-chip storage
// Assumes: push and pop clocks are pins much slower than i_clk
// Notes:   change width or depth settings only together with a clear
// Operation
// - write on push edge when not full
// - full flag high; writes ignored while full
// - empty flag; reads ignored while empty, except that a pipe-mode pop edge still loads o_pop_data from the stage
// - nearly-full and nearly-empty flags active high
// - data width 1, 2, 4, 9, 18, 36
// - push edge polarity selectable
// - pop edge polarity selectable independently
// - active-high clear restores initial state
// - pipe option adds output register stage
// - depth setting cascades blocks for depth
// - WIDTH_BLOCKS parameter cascades blocks side by side
// - block holds 4608 bits, six aspect ratios
// - own pointers, metastability-safe crossing
`timescale 1ns/1ps
`default_nettype none
module fifo_ctrl #(
  parameter int DEPTH_BLOCKS = 1,
  parameter int WIDTH_BLOCKS = 1,
  parameter int DW           = fifo_ctrl_pkg::MAX_WIDTH * WIDTH_BLOCKS,
  parameter int DSEL_W       = (DEPTH_BLOCKS > 1) ? $clog2(DEPTH_BLOCKS) : 1
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  input  wire logic                                i_push_clk,
  input  wire logic                                i_push_falling,
  input  wire logic                                i_push_enable,
  input  wire logic [DW-1:0]                       i_push_data_bus,
  input  wire logic [fifo_ctrl_pkg::THRESH_W-1:0]  i_nearly_full_threshold,
  input  wire logic                                i_pop_clk,
  input  wire logic                                i_pop_falling,
  input  wire logic                                i_pop_enable,
  input  wire logic [fifo_ctrl_pkg::THRESH_W-1:0]  i_nearly_empty_threshold,
  input  wire logic                                i_pipe,
  input  wire logic                                i_fifo_clear,
  input  wire logic [DSEL_W-1:0]                   i_depth_sel,
  input  wire logic [fifo_ctrl_pkg::WSEL_W-1:0]    i_width_sel,
  output logic [DW-1:0]                            o_pop_data,
  output logic                                     o_full,
  output logic                                     o_nearly_full_flag,
  output logic                                     o_empty,
  output logic                                     o_nearly_empty_flag
);
  localparam int WORDS = fifo_ctrl_pkg::MAX_DEPTH * DEPTH_BLOCKS;
  localparam int AW    = $clog2(WORDS);
  localparam int CW    = AW + 1;
  localparam int COL_W = fifo_ctrl_pkg::MAX_WIDTH;
  localparam int ROW_W = COL_W * WIDTH_BLOCKS;

  // one block's depth for a width code; unknown codes take the widest
  function automatic logic [CW-1:0] block_depth(input logic [2:0] sel);
    logic [12:0] d;
    d = fifo_ctrl_pkg::DEPTH_X36;
    case (sel)
      fifo_ctrl_pkg::WSEL_X1:  d = fifo_ctrl_pkg::DEPTH_X1;
      fifo_ctrl_pkg::WSEL_X2:  d = fifo_ctrl_pkg::DEPTH_X2;
      fifo_ctrl_pkg::WSEL_X4:  d = fifo_ctrl_pkg::DEPTH_X4;
      fifo_ctrl_pkg::WSEL_X9:  d = fifo_ctrl_pkg::DEPTH_X9;
      fifo_ctrl_pkg::WSEL_X18: d = fifo_ctrl_pkg::DEPTH_X18;
      default:                 d = fifo_ctrl_pkg::DEPTH_X36;
    endcase
    return CW'(d);
  endfunction

  // one block's word width for a width code
  function automatic logic [5:0] block_bits(input logic [2:0] sel);
    logic [5:0] b;
    b = fifo_ctrl_pkg::BITS_X36;
    case (sel)
      fifo_ctrl_pkg::WSEL_X1:  b = fifo_ctrl_pkg::BITS_X1;
      fifo_ctrl_pkg::WSEL_X2:  b = fifo_ctrl_pkg::BITS_X2;
      fifo_ctrl_pkg::WSEL_X4:  b = fifo_ctrl_pkg::BITS_X4;
      fifo_ctrl_pkg::WSEL_X9:  b = fifo_ctrl_pkg::BITS_X9;
      fifo_ctrl_pkg::WSEL_X18: b = fifo_ctrl_pkg::BITS_X18;
      default:                 b = fifo_ctrl_pkg::BITS_X36;
    endcase
    return b;
  endfunction

  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [DW-1:0] rd_stage;
  logic          push_edge;
  logic          pop_edge;

  // push and pop clock pins, each with its own polarity
  pin_edge_detect #(
    .STAGES    (fifo_ctrl_pkg::SYNC_STAGES)
  ) u_push_edge (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_push_clk),
    .i_falling (i_push_falling),
    .o_edge    (push_edge)
  );

  pin_edge_detect #(
    .STAGES    (fifo_ctrl_pkg::SYNC_STAGES)
  ) u_pop_edge (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_pop_clk),
    .i_falling (i_pop_falling),
    .o_edge    (pop_edge)
  );

  // active depth: block depth times cascaded blocks
  wire logic [CW-1:0] sel_blocks   = CW'(i_depth_sel) + CW'(1);
  wire logic [CW-1:0] blocks_used  =
    (sel_blocks > CW'(DEPTH_BLOCKS)) ? CW'(DEPTH_BLOCKS) : sel_blocks;  // only blocks built
  wire logic [CW-1:0] raw_depth    = CW'(block_depth(i_width_sel) * blocks_used);
  wire logic [CW-1:0] max_depth    = CW'(WORDS);
  wire logic [CW-1:0] active_depth = (raw_depth > max_depth) ? max_depth : raw_depth;
  wire logic [CW-1:0] last_index   = active_depth - CW'(1);

  // active word width: block width times side-by-side blocks
  wire logic [7:0]    eff_bits     = 8'(block_bits(i_width_sel) * WIDTH_BLOCKS);
  wire logic [DW-1:0] width_mask   = (DW'(1) << eff_bits) - DW'(1);

  // accepted requests
  wire logic do_push = push_edge && i_push_enable && !o_full;
  wire logic do_pop  = pop_edge && i_pop_enable && !o_empty;

  // pointer wrap at the active depth
  wire logic [AW-1:0] next_wr_ptr = ({1'b0, wr_ptr} >= last_index) ? '0 : wr_ptr + AW'(1);
  wire logic [AW-1:0] next_rd_ptr = ({1'b0, rd_ptr} >= last_index) ? '0 : rd_ptr + AW'(1);

  // count after this cycle's push and pop
  wire logic [CW-1:0] next_count =
    (do_push && !do_pop) ? count + CW'(1) :
    (do_pop && !do_push) ? count - CW'(1) : count;

  // flag values derived from the next count
  wire logic next_full   = (next_count >= active_depth);
  wire logic next_empty  = (next_count == '0);
  wire logic next_nfull  = (next_count >= CW'(i_nearly_full_threshold));
  wire logic next_nempty = (next_count <= CW'(i_nearly_empty_threshold));

  // storage: one column per side-by-side block, each as deep as all depth blocks
  wire logic [ROW_W-1:0] push_row = ROW_W'(i_push_data_bus & width_mask);
  logic      [ROW_W-1:0] rd_row;

  for (genvar b = 0; b < WIDTH_BLOCKS; b++) begin : g_column
    logic [COL_W-1:0] col [0:WORDS-1];

    // column write on each accepted push; a clear discards it
    always_ff @(posedge i_clk) begin
      if (do_push && !i_fifo_clear) begin
        col[wr_ptr] <= push_row[b*COL_W +: COL_W];
      end
    end

    // column read at the oldest entry
    assign rd_row[b*COL_W +: COL_W] = col[rd_ptr];
  end

  // oldest word, masked to the active width
  wire logic [DW-1:0] rd_word = DW'(rd_row) & width_mask;

  // write pointer, wraps at the active depth
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
    end else if (i_fifo_clear) begin
      wr_ptr <= '0;
    end else if (do_push) begin
      wr_ptr <= next_wr_ptr;
    end
  end

  // read pointer, wraps at the active depth
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ptr <= '0;
    end else if (i_fifo_clear) begin
      rd_ptr <= '0;
    end else if (do_pop) begin
      rd_ptr <= next_rd_ptr;
    end
  end

  // stored word count after both sides' events
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= '0;
    end else if (i_fifo_clear) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // full flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_full <= fifo_ctrl_pkg::RST_FULL;
    end else if (i_fifo_clear) begin
      o_full <= fifo_ctrl_pkg::RST_FULL;
    end else begin
      o_full <= next_full;
    end
  end

  // nearly-full flag, active high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_nearly_full_flag <= fifo_ctrl_pkg::RST_FULL;
    end else if (i_fifo_clear) begin
      o_nearly_full_flag <= fifo_ctrl_pkg::RST_FULL;
    end else begin
      o_nearly_full_flag <= next_nfull;
    end
  end

  // empty flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_empty <= fifo_ctrl_pkg::RST_EMPTY;
    end else if (i_fifo_clear) begin
      o_empty <= fifo_ctrl_pkg::RST_EMPTY;
    end else begin
      o_empty <= next_empty;
    end
  end

  // nearly-empty flag, active high
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_nearly_empty_flag <= fifo_ctrl_pkg::RST_EMPTY;
    end else if (i_fifo_clear) begin
      o_nearly_empty_flag <= fifo_ctrl_pkg::RST_EMPTY;
    end else begin
      o_nearly_empty_flag <= next_nempty;
    end
  end

  // read stage, loaded on each accepted pop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_stage <= '0;
    end else if (i_fifo_clear) begin
      rd_stage <= '0;
    end else if (do_pop) begin
      rd_stage <= rd_word;
    end
  end

  // direct word on an accepted pop, or the stage on every pop edge
  wire logic          out_load = i_pipe ? pop_edge : do_pop;
  wire logic [DW-1:0] out_word = i_pipe ? rd_stage : rd_word;

  // read data output register; a pipe change alone never moves it
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pop_data <= '0;
    end else if (i_fifo_clear) begin
      o_pop_data <= '0;
    end else if (out_load) begin
      o_pop_data <= out_word;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/fifo_ctrl_pkg.sv */
// Purpose: shared constants for the embedded fifo control unit
// Assumes: one system clock; push and pop clocks arrive as pins
// Notes:   width codes select the aspect ratio of one memory block
package fifo_ctrl_pkg;
  localparam int          BLOCK_BITS  = 4608;  // storage bits in one block
  localparam int          MAX_WIDTH   = 36;    // widest aspect ratio
  localparam int          MAX_DEPTH   = 4096;  // deepest aspect ratio
  localparam int          THRESH_W    = 8;     // almost-flag threshold width
  localparam int          WSEL_W      = 3;     // width code width
  localparam int          SYNC_STAGES = 3;     // pin synchroniser depth
  // width codes and the aspect ratio each selects
  localparam logic [2:0]  WSEL_X1     = 3'h0;  // 4096 x 1
  localparam logic [2:0]  WSEL_X2     = 3'h1;  // 2048 x 2
  localparam logic [2:0]  WSEL_X4     = 3'h2;  // 1024 x 4
  localparam logic [2:0]  WSEL_X9     = 3'h3;  // 512 x 9
  localparam logic [2:0]  WSEL_X18    = 3'h4;  // 256 x 18
  localparam logic [2:0]  WSEL_X36    = 3'h5;  // 128 x 36
  localparam logic [12:0] DEPTH_X1    = 13'h1000;
  localparam logic [12:0] DEPTH_X2    = 13'h0800;
  localparam logic [12:0] DEPTH_X4    = 13'h0400;
  localparam logic [12:0] DEPTH_X9    = 13'h0200;
  localparam logic [12:0] DEPTH_X18   = 13'h0100;
  localparam logic [12:0] DEPTH_X36   = 13'h0080;
  localparam logic [5:0]  BITS_X1     = 6'h01;
  localparam logic [5:0]  BITS_X2     = 6'h02;
  localparam logic [5:0]  BITS_X4     = 6'h04;
  localparam logic [5:0]  BITS_X9     = 6'h09;
  localparam logic [5:0]  BITS_X18    = 6'h12;
  localparam logic [5:0]  BITS_X36    = 6'h24;
  // reset values of the flags
  localparam logic        RST_EMPTY   = 1'b1;
  localparam logic        RST_FULL    = 1'b0;
endpackage

/* File: rtl/pin_edge_detect.sv */
// Purpose: synchronise a clock pin and flag its chosen edge
// Assumes: pin period well above four system clock periods
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect #(
  parameter int STAGES = 3
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  input  wire logic i_falling,
  output logic      o_edge
);
  logic [STAGES-1:0] sync;
  logic              level;
  wire logic         settled = sync[STAGES-1];
  wire logic         agreed  = (sync[STAGES-2] == settled);
  wire logic         moved   = agreed && (settled != level);

  // three-stage shift; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync <= '0;
    end else begin
      sync <= {sync[STAGES-2:0], i_pin};
    end
  end

  // settled level and one-cycle pulse on the selected edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level  <= 1'b0;
      o_edge <= 1'b0;
    end else begin
      if (moved) begin
        level <= settled;
      end
      o_edge <= moved && (settled == ~i_falling);
    end
  end
endmodule
`default_nettype wire

/* File: test/fifo_ctrl_monitor.sv */
// Purpose: port-level checks for the fifo control unit
// Assumes: one system clock, reset active low
// Notes:   bound into every fifo_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module fifo_ctrl_monitor #(
  parameter int DW = 36
) (
  input wire logic          i_clk,
  input wire logic          i_reset_n,
  input wire logic          i_push_enable,
  input wire logic          i_pop_enable,
  input wire logic          i_pipe,
  input wire logic          i_fifo_clear,
  input wire logic [2:0]    i_width_sel,
  input wire logic [DW-1:0] o_pop_data,
  input wire logic          o_full,
  input wire logic          o_nearly_full_flag,
  input wire logic          o_empty,
  input wire logic          o_nearly_empty_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // clear and the state it must leave
  sequence s_clear;
    i_fifo_clear;
  endsequence
  sequence s_initial;
    o_empty && !o_full && !o_nearly_full_flag && o_nearly_empty_flag;
  endsequence
  AST_CLEAR_STATE: assert property (s_clear |=> s_initial)
    else $error("clear left fifo not empty");
  AST_FULL_NOT_EMPTY: assert property (!(o_full && o_empty))
    else $error("full and empty together");
  AST_FULL_HOLDS: assert property (o_full && !i_pop_enable && !i_fifo_clear |=> o_full)
    else $error("full dropped without a pop");
  AST_EMPTY_HOLDS: assert property (o_empty && !i_push_enable && !i_fifo_clear |=> o_empty)
    else $error("empty dropped without a push");
  AST_PUSH_CAUSE: assert property ($fell(o_empty) |-> $past(i_push_enable))
    else $error("word stored without push request");
  AST_POP_CAUSE: assert property ($rose(o_empty) |-> $past(i_pop_enable) || $past(i_fifo_clear))
    else $error("fifo emptied without pop");
  AST_REFUSED_POP: assert property (o_empty && !i_pipe && !i_fifo_clear |=> $stable(o_pop_data))
    else $error("read data moved while empty");
  AST_WIDTH_MASK: assert property (i_width_sel == 3'h3 && $past(i_width_sel) == 3'h3
    |-> o_pop_data[DW-1:9] == '0)
    else $error("bits above nine bit width set");
endmodule
bind fifo_ctrl fifo_ctrl_monitor #(.DW(DW)) u_fifo_ctrl_monitor (.*);
`default_nettype wire

/* File: test/fifo_ctrl_tb_top.sv */
// Purpose: self-checking bench for the fifo control unit
// Assumes: default one block deep and wide
// Notes:   width and pipe change only together with a clear
`timescale 1ns/1ps
`default_nettype none
module fifo_ctrl_tb_top;
  logic        i_clk, i_reset_n, i_push_clk, i_push_falling, i_push_enable;
  logic        i_pop_clk, i_pop_falling, i_pop_enable, i_pipe, i_fifo_clear;
  logic        o_full, o_nearly_full_flag, o_empty, o_nearly_empty_flag;
  logic [35:0] i_push_data_bus, o_pop_data;
  logic [7:0]  i_nearly_full_threshold, i_nearly_empty_threshold;
  logic [2:0]  i_width_sel;
  logic [0:0]  i_depth_sel;
  logic [3:0]  half;
  int          bad_count, num_checks;
  logic [5:0]  bits_tab [6] = '{fifo_ctrl_pkg::BITS_X1, fifo_ctrl_pkg::BITS_X2,
    fifo_ctrl_pkg::BITS_X4, fifo_ctrl_pkg::BITS_X9, fifo_ctrl_pkg::BITS_X18,
    fifo_ctrl_pkg::BITS_X36};
  fifo_ctrl u_fifo_ctrl (.*);
  fifo_user u_fifo_user (.i_clk(i_clk), .i_half(half), .o_push_clk(i_push_clk),
    .o_push_enable(i_push_enable), .o_push_data(i_push_data_bus),
    .o_pop_clk(i_pop_clk), .o_pop_enable(i_pop_enable));
  // compare and count
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [35:0] flags();
    return {32'h0, o_full, o_nearly_full_flag, o_empty, o_nearly_empty_flag};
  endfunction
  task automatic restart(input logic [2:0] w, input logic p);
    @(posedge i_clk) #1;
    i_width_sel = w;
    i_pipe = p;
    i_fifo_clear = 1'h1;
    @(posedge i_clk) #1;
    i_fifo_clear = 1'h0;
    check(flags(), 36'h3);
  endtask
  // fifo order, both edge polarities, refused pop
  task automatic t_order();
    for (int k = 0; k < 2; k++) begin
      i_push_falling = k[0];
      i_pop_falling = !k[0];
      half = k[0] ? 4'h7 : 4'h3;
      restart(fifo_ctrl_pkg::WSEL_X36, 1'h0);
      u_fifo_user.xfer(1'h0, 1'h1, 36'h1_2345_6789);
      u_fifo_user.xfer(1'h0, 1'h1, 36'hA_BCDE_F012);
      check(flags(), 36'h0);
      u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
      check(o_pop_data, 36'h1_2345_6789);
      check(flags(), 36'h1);
      u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
      u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
      check(o_pop_data, 36'hA_BCDE_F012);
      check(flags(), 36'h3);
    end
    $display("order test done");
  endtask
  // fill to full, refused push, nearly-full level
  task automatic t_full();
    half = 4'h3;
    i_depth_sel = 1'h1;
    restart(fifo_ctrl_pkg::WSEL_X36, 1'h0);
    for (int n = 0; n < 128; n++) begin
      u_fifo_user.xfer(1'h0, 1'h1, 36'(n + 5));
      if (n == 125) check(flags(), 36'h0);
      if (n == 126) check(flags(), 36'h4);
    end
    check(flags(), 36'hC);
    u_fifo_user.xfer(1'h0, 1'h1, 36'hF_FFFF_FFFF);
    check(flags(), 36'hC);
    u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
    check(o_pop_data, 36'h5);
    check(flags(), 36'h4);
    i_depth_sel = 1'h0;
    $display("full test done");
  endtask
  // every width code keeps only its own bits
  task automatic t_width();
    for (int c = 0; c < 6; c++) begin
      restart(3'(c), 1'h0);
      u_fifo_user.xfer(1'h0, 1'h1, 36'hF_FFFF_FFFF);
      u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
      check(o_pop_data, ~(36'hF_FFFF_FFFF << bits_tab[c]));
    end
    $display("width test done");
  endtask
  // pipelined output lags one pop edge
  task automatic t_pipe();
    restart(fifo_ctrl_pkg::WSEL_X36, 1'h1);
    u_fifo_user.xfer(1'h0, 1'h1, 36'h0_0000_0AAA);
    u_fifo_user.xfer(1'h0, 1'h1, 36'h0_0000_0BBB);
    u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
    check(o_pop_data, 36'h0);
    u_fifo_user.xfer(1'h1, 1'h1, 36'h0);
    check(o_pop_data, 36'h0_0000_0AAA);
    u_fifo_user.xfer(1'h1, 1'h0, 36'h0);
    check(o_pop_data, 36'h0_0000_0BBB);
    $display("pipe test done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  // watchdog on the whole run
  initial begin
    repeat (100000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end
  initial begin
    {i_reset_n, i_push_falling, i_pop_falling, i_pipe, i_fifo_clear} = 5'h0;
    i_nearly_full_threshold = 8'h7F;
    i_nearly_empty_threshold = 8'h01;
    {i_width_sel, i_depth_sel, half} = 8'hA3;
    repeat (4) @(posedge i_clk);
    #1 i_reset_n = 1'h1;
    repeat (6) @(posedge i_clk);
    t_order();
    t_full();
    t_width();
    t_pipe();
    stop_test();
  end
endmodule
`default_nettype wire

/* File: test/fifo_user.sv */
// Purpose: user logic writing and reading the fifo through its pins
// Assumes: half period of the pins given in system clocks, 3 or more
// Notes:   pins stand low between transfers
`timescale 1ns/1ps
`default_nettype none
module fifo_user (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_half,
  output logic            o_push_clk,
  output logic            o_push_enable,
  output logic [35:0]     o_push_data,
  output logic            o_pop_clk,
  output logic            o_pop_enable
);
  initial begin
    {o_push_clk, o_push_enable, o_pop_clk, o_pop_enable} = 4'h0;
    o_push_data = 36'h0;
  end
  // one full pin period, request held across both edges
  task automatic xfer(input logic pop, input logic en, input logic [35:0] d);
    @(posedge i_clk) #1;
    o_pop_enable = pop & en;
    o_push_enable = !pop & en;
    o_push_data = d;
    repeat (2) @(posedge i_clk) #1;
    for (int e = 0; e < 2; e++) begin
      o_pop_clk = o_pop_clk ^ pop;
      o_push_clk = o_push_clk ^ !pop;
      repeat (i_half) @(posedge i_clk) #1;
    end
    repeat (6) @(posedge i_clk) #1;
    o_push_enable = 1'h0;
    o_pop_enable = 1'h0;
    o_push_data = ~d;  // released bus shows no stale word
  endtask
endmodule
`default_nettype wire
